// ---- pkg/lbam_pkg.sv ----
`default_nettype none
package lbam_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] LBAM_ADDR_UPPER = 8'h5C;
    localparam logic [7:0] LBAM_ADDR_LOWER = 8'h5D;
    localparam logic [7:0] LBAM_ADDR_SIZE  = 8'h5E;
    localparam logic [7:0] LBAM_ADDR_LEAK  = 8'h5F;
    localparam logic [7:0] LBAM_ADDR_STAT  = 8'h70;
    localparam logic [7:0] LBAM_RST_UPPER  = 8'h06;
    localparam logic [7:0] LBAM_RST_LOWER  = 8'h04;
    localparam logic [7:0] LBAM_RST_SIZE   = 8'h08;
    localparam logic [7:0] LBAM_RST_LEAK   = 8'h01;
    localparam int         LBAM_LEAK_LSB   = 0;
    localparam int         LBAM_LEAK_W     = 2;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint     LBAM_CLK_HZ     = 100000000;
    localparam longint     LBAM_CYCLE_MS   = 128;
    localparam longint     LBAM_CYCLE_CLKS = LBAM_CLK_HZ / 1000 * LBAM_CYCLE_MS;
endpackage
`default_nettype wire

// ---- rtl/lbam_timebase.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbam_timebase #(
    parameter int unsigned PERIOD = int'(lbam_pkg::LBAM_CYCLE_CLKS)
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    output var  logic tick
);
    logic [31:0] cnt_q;
    // free running divider, one pulse per monitoring cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 32'h0;
            tick  <= 1'b0;
        end else if (cnt_q == PERIOD - 1) begin
            cnt_q <= 32'h0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/lbam_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - one observation per 128 ms cycle
// - bad cycle adds one to accumulator, up to size
// - leak one after 1/2/4/8 clean cycles
// - leak rate is fill rate divided
// - alarm clears at lower threshold
module lbam_monitor #(
    parameter int unsigned CYCLE_CLKS = int'(lbam_pkg::LBAM_CYCLE_CLKS)
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       in_bad,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output var  logic [7:0] reg_rdata,
    output var  logic [7:0] level,
    output var  logic       alarm
);
    // ----------------------------------------------------------------
    // input synchroniser
    // ----------------------------------------------------------------
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic bad_q;
    logic seen_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            s1_q <= in_bad;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                bad_q <= s3_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] upper_q;
    logic [7:0] lower_q;
    logic [7:0] size_q;
    logic [1:0] leak_q;
    wire        wr_up   = reg_wr && (reg_addr == lbam_pkg::LBAM_ADDR_UPPER);
    wire        wr_lo   = reg_wr && (reg_addr == lbam_pkg::LBAM_ADDR_LOWER);
    wire        wr_sz   = reg_wr && (reg_addr == lbam_pkg::LBAM_ADDR_SIZE);
    wire        wr_lk   = reg_wr && (reg_addr == lbam_pkg::LBAM_ADDR_LEAK);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            upper_q <= lbam_pkg::LBAM_RST_UPPER;
            lower_q <= lbam_pkg::LBAM_RST_LOWER;
            size_q  <= lbam_pkg::LBAM_RST_SIZE;
            leak_q  <= lbam_pkg::LBAM_RST_LEAK[1:0];
        end else begin
            if (wr_up) upper_q <= reg_wdata;
            if (wr_lo) lower_q <= reg_wdata;
            if (wr_sz) size_q  <= reg_wdata;
            if (wr_lk) leak_q  <= reg_wdata[1:0];
        end
    end

    // read mux, unused bits of leak register read as zero
    logic [7:0] rd_d;
    always_comb begin
        if (reg_addr == lbam_pkg::LBAM_ADDR_UPPER) rd_d = upper_q;
        else if (reg_addr == lbam_pkg::LBAM_ADDR_LOWER) rd_d = lower_q;
        else if (reg_addr == lbam_pkg::LBAM_ADDR_SIZE) rd_d = size_q;
        else if (reg_addr == lbam_pkg::LBAM_ADDR_LEAK) rd_d = {6'h00, leak_q};
        else if (reg_addr == lbam_pkg::LBAM_ADDR_STAT) rd_d = {7'h00, alarm};
        else rd_d = 8'h00;
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) reg_rdata <= 8'h00;
        else reg_rdata <= rd_d;
    end

    // ----------------------------------------------------------------
    // monitoring cycle timebase
    // ----------------------------------------------------------------
    logic tick;
    lbam_timebase #(.PERIOD(CYCLE_CLKS)) u_tb (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // bucket
    // ----------------------------------------------------------------
    logic [2:0] clean_q;
    wire  [2:0] leak_last = 3'((4'h1 << leak_q) - 4'h1);
    // at or past the end, so a shorter rate written mid-run still leaks
    wire        leak_now  = tick && !seen_q && (clean_q >= leak_last);
    wire        fill_now  = tick && seen_q;
    logic [7:0] level_d;
    always_comb begin
        level_d = level;
        if (fill_now) begin
            if (level < size_q) level_d = level + 8'h01;
        end else if (leak_now) begin
            if (level != 8'h00) level_d = level - 8'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            seen_q  <= 1'b0;
            clean_q <= 3'h0;
            level   <= 8'h00;
            alarm   <= 1'b0;
        end else begin
            // latch any bad sample between ticks; a sample on the tick clock itself is dropped
            seen_q <= tick ? 1'b0 : (seen_q | bad_q);
            if (fill_now || leak_now) clean_q <= 3'h0;
            else if (tick) clean_q <= clean_q + 3'h1;
            level <= level_d;
            if (level_d >= upper_q) alarm <= 1'b1;
            else if (level_d <= lower_q) alarm <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // check sequences
    // ----------------------------------------------------------------
    // a cycle tick that closes a cycle with a bad sample
    sequence s_tick_bad;
        tick && seen_q;
    endsequence
    // a cycle tick that closes a clean run long enough to leak
    sequence s_tick_leak_due;
        tick && !seen_q && (clean_q >= leak_last);
    endsequence

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_fill_step: assert property (@(posedge clk_sys) disable iff (!resetn)
        fill_now && level < size_q |=> level == $past(level) + 8'h01)
        else $error("fill did not add one");
    chk_size_cap: assert property (@(posedge clk_sys) disable iff (!resetn)
        level > $past(level) |-> level <= size_q)
        else $error("level grew past size");
    chk_no_leak_early: assert property (@(posedge clk_sys) disable iff (!resetn)
        !fill_now && tick && clean_q < leak_last |=> level == $past(level))
        else $error("leak before period");
    chk_leak_step: assert property (@(posedge clk_sys) disable iff (!resetn)
        leak_now && level != 8'h00 |=> level == $past(level) - 8'h01)
        else $error("leak did not remove one");
    chk_alarm_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        level_d <= lower_q && level_d < upper_q |=> !alarm)
        else $error("alarm not cleared");
    chk_alarm_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        level_d >= upper_q |=> alarm)
        else $error("alarm not raised");
    chk_quiet_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !tick |=> level == $past(level))
        else $error("level moved between cycles");

    // bucket steps built from the tick sequences
    chk_fill_cap: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_tick_bad ##0 (level >= size_q) |=> level == $past(level))
        else $error("fill went past size");
    chk_leak_floor: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_tick_leak_due ##0 (level == 8'h00) |=> level == 8'h00)
        else $error("leak went below zero");
    chk_leak_due: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_tick_leak_due ##0 (level != 8'h00) |=> level == $past(level) - 8'h01)
        else $error("due leak missed");

    // clean run counter
    chk_clean_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
        fill_now || leak_now |=> clean_q == 3'h0)
        else $error("clean run not restarted");
    chk_clean_count: assert property (@(posedge clk_sys) disable iff (!resetn)
        tick && !fill_now && !leak_now |=> clean_q == $past(clean_q) + 3'h1)
        else $error("clean cycle not counted");

    // per-cycle bad latch
    chk_seen_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        tick |=> !seen_q)
        else $error("bad latch not cleared at tick");
    chk_seen_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        seen_q && !tick |=> seen_q)
        else $error("bad latch dropped mid cycle");
    chk_bad_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
        bad_q && !tick |=> seen_q)
        else $error("bad sample not latched");

    // synchroniser and timebase
    chk_sync_agree: assert property (@(posedge clk_sys) disable iff (!resetn)
        s2_q == s3_q |=> bad_q == $past(s3_q))
        else $error("agreed input not taken");
    chk_tick_single: assert property (@(posedge clk_sys) disable iff (!resetn)
        tick |=> !tick)
        else $error("tick wider than one cycle");

    // registers and read path
    chk_leak_wr: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_lk |=> leak_q == $past(reg_wdata[1:0]))
        else $error("leak field not written");
    chk_upper_wr: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_up |=> upper_q == $past(reg_wdata))
        else $error("upper threshold not written");
    chk_lower_wr: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_lo |=> lower_q == $past(reg_wdata))
        else $error("lower threshold not written");
    chk_rdata_stat: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_addr == lbam_pkg::LBAM_ADDR_STAT |=> reg_rdata == {7'h00, $past(alarm)})
        else $error("status read wrong");

    // alarm hysteresis
    chk_alarm_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        level_d > lower_q && level_d < upper_q |=> alarm == $past(alarm))
        else $error("alarm moved inside band");
endmodule
`default_nettype wire

// ---- verification/lbam_monitor_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbam_monitor_tb;
    // ----------------------------------------------------------------
    // signals and instance
    // ----------------------------------------------------------------
    localparam int CYC = 20;
    logic        clk_sys   = 1'b0;
    logic        resetn    = 1'b0;
    logic        in_bad    = 1'b0;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [7:0]  level;
    logic        alarm;
    logic [7:0]  rd;
    logic [7:0]  lv;
    logic [15:0] rows [6]  = '{16'h5C06, 16'h5D04, 16'h5E08, 16'h5F01, 16'h7000, 16'h1000};
    int          error_cnt = 0;
    int          compares  = 0;
    int          n;
    lbam_monitor #(.CYCLE_CLKS(CYC)) u_lbam_monitor (.clk_sys(clk_sys), .resetn(resetn),
        .in_bad(in_bad), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .level(level), .alarm(alarm));
    // 100 mhz clock
    initial forever #5 clk_sys = ~clk_sys;
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys) reg_addr = a;
        @(negedge clk_sys) d = reg_rdata;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys) begin
            reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        end
        @(negedge clk_sys) reg_wr = 1'b0;
    endtask
    // cycles until level moves, bounded
    task automatic wait_chg(output int cnt);
        logic [7:0] old;
        old = level;
        cnt = 0;
        while (level === old && cnt < 1000) begin
            @(negedge clk_sys);
            cnt++;
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk_sys);
        check(level, 8'h00);
        check({7'h00, alarm}, 8'h00);
        resetn = 1'b1;
        foreach (rows[i]) begin
            rd_reg(rows[i][15:8], rd);
            check(rd, rows[i][7:0]);
        end
        wr_reg(8'h5F, 8'hFF);
        wr_reg(8'h10, 8'h55);
        rd_reg(8'h5F, rd);
        check(rd, 8'h03);
        rd_reg(8'h10, rd);
        check(rd, 8'h00);
        wr_reg(8'h5F, 8'h00);
        // fill: one step per bad cycle
        in_bad = 1'b1;
        for (int k = 1; k <= 8; k++) begin
            wait_chg(n);
            check(level, 8'(k));
            check({7'h00, alarm}, {7'h00, k >= 6});
            if (k > 1) check(n[7:0], 8'(CYC));
        end
        repeat (300) @(negedge clk_sys);
        check(level, 8'h08);
        rd_reg(8'h70, rd);
        check(rd, 8'h01);
        // leak at each rate, second interval is phase free
        in_bad = 1'b0;
        lv = 8'h08;
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'h5F, 8'(c));
            for (int j = 0; j < 2; j++) begin
                wait_chg(n);
                lv = lv - 8'h01;
                check(level, lv);
                check({7'h00, alarm}, {7'h00, lv > 8'h04});
                if (j == 1) check(n[7:0], 8'(CYC << c));
            end
        end
        repeat (400) @(negedge clk_sys);
        check(level, 8'h00);
        rd_reg(8'h70, rd);
        check(rd, 8'h00);
        // mid-run reset returns upper threshold register to its default
        wr_reg(8'h5C, 8'h22);
        @(negedge clk_sys) resetn = 1'b0;
        @(negedge clk_sys) resetn = 1'b1;
        rd_reg(8'h5C, rd);
        check(rd, 8'h06);
        tally_and_finish();
    end
endmodule
`default_nettype wire
